// ==== shared/pwu_pkg.sv ====
// Package for the pin wake-up interrupt unit: register map, fields, resets
package pwu_pkg;

  // Register word offsets (byte addresses on the Avalon bus)
  localparam logic [3:0] OFS_STATUS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PIN_ENABLE  = 4'h4;
  localparam logic [3:0] OFS_POLARITY    = 4'h8;
  localparam logic [3:0] OFS_POWER_MODE  = 4'hC;

  // Status/control field positions
  localparam int BIT_MODE   = 0;
  localparam int BIT_IRQ_EN = 1;
  localparam int BIT_ACK    = 2;
  localparam int BIT_FLAG   = 3;

  // Power mode field positions
  localparam int BIT_WAIT    = 0;
  localparam int BIT_SHALLOW = 1;
  localparam int BIT_DEEP    = 2;

  // Reset values
  localparam logic [7:0]  RST_PIN_ENABLE = 8'h00;
  localparam logic [7:0]  RST_POLARITY   = 8'h00;
  localparam logic        RST_MODE       = 1'b0;
  localparam logic        RST_IRQ_EN     = 1'b0;
  localparam logic [2:0]  RST_POWER_MODE = 3'h0;
  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } pwu_bus_t;

endpackage : pwu_pkg

// ==== verilog/pwu_top.sv ====
// Pin wake-up interrupt unit with Avalon-MM register slave
// What this block does
// - Each pin enable bit independently lets its pin set the flag.
// - Mode bit: 0 edge only (levels still latch in shallow stop), 1 edge plus level, for all pins.
// - Polarity bit 0 falling/low, 1 rising/high per pin.
// - Interrupt enable bit 1 gates the request to the CPU.
// - Flag bit 3 reads detected events; writes leave it unchanged.
// - Writing 1 to acknowledge bit 2 clears flag; reads back 0.
// - Status/control bits 7 to 4 always read zero.
// - Falling edge: enabled input high one cycle, low the next.
// - Rising edge: enabled input low one cycle, high the next.
// - Edge mode: valid edge sets flag; request follows interrupt enable.
// - Edge mode: acknowledge clears the flag unless an event sets it in the same cycle.
// - Unit keeps running in wait; enabled event with irq wakes core.
// - Shallow stop: raw levels registered on the clock, unsynchronised, and wake the core.
// - Deeper stop disables unit; afterwards all registers at reset.
// - Debug halt leaves detection, flagging and requests unchanged.
// - Level mode: asserted level held on enabled pin sets flag.
// - Level mode: acknowledge leaves flag set if an enabled pin is still asserted.
// - With resistor on and pin enabled, polarity 0 selects pull-up, 1 pull-down.
`timescale 1ns/1ps

module pwu_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [7:0]  WAKE_INPUT_N,
  input  wire logic [7:0]  PULL_ENABLE,
  input  wire logic        DEBUG_HALT,
  output logic             WAKE_IRQ,
  output logic             CORE_WAKE,
  output logic      [7:0]  PULL_UP_EN,
  output logic      [7:0]  PULL_DOWN_EN
);

  typedef struct packed {
    logic [7:0]        sync1;
    logic [7:0]        sync2;
    logic [7:0]        prev;
    logic              prev_ok;
    logic [7:0]        pin_enable;
    logic [7:0]        polarity;
    logic              mode;
    logic              irq_en;
    logic              flag;
    logic [2:0]        power;
    logic              deep_seen;
    pwu_pkg::pwu_bus_t bus;
    logic [31:0]       rdata;
    logic              irq;
    logic              wake;
    logic [7:0]        pu;
    logic [7:0]        pd;
  } pwu_state_t;

  pwu_state_t s_q;
  pwu_state_t s_d;

  logic [7:0] asserted;
  logic [7:0] edge_hit;
  logic       event_now;
  logic       wr_hit;
  logic       rd_hit;
  logic       deep_now;
  logic       ack_wr;
  logic       async_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Shallow stop: a raw asserted level is registered on SYS_CLK, bypassing
  // the synchronisers. Cleared by acknowledge or by leaving shallow stop.
  logic async_q;

  assign async_hit = s_q.power[pwu_pkg::BIT_SHALLOW] &
                     (|(s_q.pin_enable & (WAKE_INPUT_N ^ ~s_q.polarity)));

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      async_q <= 1'b0;
    end else if (async_hit) begin
      async_q <= 1'b1;
    end else if (ack_wr || !s_q.power[pwu_pkg::BIT_SHALLOW]) begin
      async_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;

    s_d.sync1 = WAKE_INPUT_N;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    s_d.prev_ok = 1'b1;

    asserted = s_q.sync2 ^ ~s_q.polarity;
    // Idle then asserted on consecutive samples
    edge_hit = asserted & ~(s_q.prev ^ ~s_q.polarity) & {8{s_q.prev_ok}};

    event_now = |(s_q.pin_enable & (edge_hit | (s_q.mode ? asserted : 8'h00)));

    wr_hit = AVS_WRITE && (s_q.bus == pwu_pkg::BUS_IDLE);
    rd_hit = AVS_READ && (s_q.bus == pwu_pkg::BUS_IDLE);
    ack_wr = wr_hit && AVS_BYTEENABLE[0] && (AVS_ADDRESS == pwu_pkg::OFS_STATUS_CTRL)
             && AVS_WRITEDATA[pwu_pkg::BIT_ACK];

    if (ack_wr) begin
      s_d.flag = 1'b0;
    end
    // Events set the flag regardless of debug halt
    if (event_now || async_q) begin
      s_d.flag = 1'b1;
    end

    // Avalon slave: one wait cycle, answer on the second
    s_d.bus   = pwu_pkg::BUS_IDLE;
    s_d.rdata = pwu_pkg::UNMAPPED_READ;
    if (wr_hit && AVS_BYTEENABLE[0]) begin
      s_d.bus = pwu_pkg::BUS_DONE;
      case (AVS_ADDRESS)
        pwu_pkg::OFS_STATUS_CTRL: begin
          s_d.mode   = AVS_WRITEDATA[pwu_pkg::BIT_MODE];
          s_d.irq_en = AVS_WRITEDATA[pwu_pkg::BIT_IRQ_EN];
        end
        pwu_pkg::OFS_PIN_ENABLE: s_d.pin_enable = AVS_WRITEDATA[7:0];
        pwu_pkg::OFS_POLARITY:   s_d.polarity   = AVS_WRITEDATA[7:0];
        pwu_pkg::OFS_POWER_MODE: s_d.power      = AVS_WRITEDATA[2:0];
        default: ;
      endcase
    end else if (wr_hit) begin
      s_d.bus = pwu_pkg::BUS_DONE;
    end else if (rd_hit) begin
      s_d.bus = pwu_pkg::BUS_DONE;
      case (AVS_ADDRESS)
        // Ack and upper bits read zero
        pwu_pkg::OFS_STATUS_CTRL:
          s_d.rdata = {28'h000_0000, s_q.flag, 1'b0, s_q.irq_en, s_q.mode};
        pwu_pkg::OFS_PIN_ENABLE: s_d.rdata = {24'h00_0000, s_q.pin_enable};
        pwu_pkg::OFS_POLARITY:   s_d.rdata = {24'h00_0000, s_q.polarity};
        pwu_pkg::OFS_POWER_MODE: s_d.rdata = {29'h0000_0000, s_q.power};
        default:                 s_d.rdata = pwu_pkg::UNMAPPED_READ;
      endcase
    end

    // Deep stop holds unit idle with registers at reset; leaving it resets power mode
    deep_now = s_q.power[pwu_pkg::BIT_DEEP];
    s_d.deep_seen = deep_now;
    if (deep_now) begin
      s_d.flag       = 1'b0;
      s_d.pin_enable = pwu_pkg::RST_PIN_ENABLE;
      s_d.polarity   = pwu_pkg::RST_POLARITY;
      s_d.mode       = pwu_pkg::RST_MODE;
      s_d.irq_en     = pwu_pkg::RST_IRQ_EN;
      s_d.prev_ok    = 1'b0;
      if (!(wr_hit && AVS_ADDRESS == pwu_pkg::OFS_POWER_MODE)) begin
        s_d.power = s_q.power;
      end
    end else if (s_q.deep_seen) begin
      s_d.power = pwu_pkg::RST_POWER_MODE;
    end

    s_d.irq  = s_d.flag & s_d.irq_en;
    // Wake from wait or shallow stop
    s_d.wake = s_d.irq & (s_d.power[pwu_pkg::BIT_WAIT] | s_d.power[pwu_pkg::BIT_SHALLOW]);

    s_d.pu = PULL_ENABLE & s_d.pin_enable & ~s_d.polarity;
    s_d.pd = PULL_ENABLE & s_d.pin_enable & s_d.polarity;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_q <= '{
        sync1: 8'h00, sync2: 8'h00, prev: 8'h00, prev_ok: 1'b0,
        pin_enable: pwu_pkg::RST_PIN_ENABLE, polarity: pwu_pkg::RST_POLARITY,
        mode: pwu_pkg::RST_MODE, irq_en: pwu_pkg::RST_IRQ_EN, flag: 1'b0,
        power: pwu_pkg::RST_POWER_MODE, deep_seen: 1'b0, bus: pwu_pkg::BUS_IDLE,
        rdata: pwu_pkg::UNMAPPED_READ, irq: 1'b0, wake: 1'b0, pu: 8'h00, pd: 8'h00
      };
    end else begin
      s_q <= s_d;
    end
  end

  // Waitrequest low only in the answer cycle
  assign AVS_WAITREQUEST = (s_q.bus != pwu_pkg::BUS_DONE);
  assign AVS_READDATA    = s_q.rdata;
  assign WAKE_IRQ        = s_q.irq;
  assign CORE_WAKE       = s_q.wake;
  assign PULL_UP_EN      = s_q.pu;
  assign PULL_DOWN_EN    = s_q.pd;

endmodule : pwu_top

// ==== testbench/pwu_properties.sv ====
// Port checker for the pin wake-up unit
`timescale 1ns/1ps
module pwu_properties (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [7:0]  PULL_ENABLE,
  input wire logic        WAKE_IRQ,
  input wire logic        CORE_WAKE,
  input wire logic [7:0]  PULL_UP_EN,
  input wire logic [7:0]  PULL_DOWN_EN
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic wr_ok;
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  sequence s_req; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
  sequence s_ans; !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endsequence
  a_one_wait:
    assert property (s_req |-> ##[0:1] s_ans) else $error("bus answer missing");
  a_idle_busy:
    assert property (!(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST) else $error("stray answer");
  a_status_zero:
    assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == pwu_pkg::OFS_STATUS_CTRL
      |-> (AVS_READDATA & 32'hFFFF_FFF4) == 32'h0000_0000) else $error("status zero bits set");
  a_irq_gate:
    assert property (wr_ok && AVS_ADDRESS == pwu_pkg::OFS_STATUS_CTRL && !AVS_WRITEDATA[1]
      |-> ##2 !WAKE_IRQ) else $error("request not masked");
  a_wake_cause:
    assert property (CORE_WAKE |-> WAKE_IRQ) else $error("wake without request");
  a_pull_excl:
    assert property ((PULL_UP_EN & PULL_DOWN_EN) == 8'h00) else $error("both pulls on");
  a_pull_src:
    assert property (((PULL_UP_EN | PULL_DOWN_EN) & ~$past(PULL_ENABLE)) == 8'h00)
      else $error("pull without enable");
  a_deep_clear:
    assert property (wr_ok && AVS_ADDRESS == pwu_pkg::OFS_POWER_MODE && AVS_WRITEDATA[2]
      |-> ##3 (!WAKE_IRQ && PULL_DOWN_EN == 8'h00)) else $error("deep stop kept state");
endmodule : pwu_properties

bind pwu_top pwu_properties u_props (.*);

// ==== testbench/pwu_pins.sv ====
// Model of the switches that drive the wake inputs
`timescale 1ns/1ps
module pwu_pins (
  input  wire logic       clk,
  output logic      [7:0] pins
);
  logic [7:0] lvl_q = 8'hFF;
  assign pins = lvl_q;
  task automatic set(input logic [7:0] l);
    @(posedge clk);
    lvl_q <= l;
  endtask : set
endmodule : pwu_pins

// ==== testbench/tb.sv ====
// Self-checking bench for the pin wake-up unit
`timescale 1ns/1ps
module tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic        halt = 1'b0;
  logic [7:0]  pull_en = 8'hFF;
  logic [31:0] rdata, junk;
  logic        waitreq, irq, wake;
  logic [7:0]  pins, pu, pd;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  pwu_top DUT (.SYS_CLK(sys_clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .WAKE_INPUT_N(pins), .PULL_ENABLE(pull_en), .DEBUG_HALT(halt),
    .WAKE_IRQ(irq), .CORE_WAKE(wake), .PULL_UP_EN(pu), .PULL_DOWN_EN(pd));
  pwu_pins u_pins (.clk(sys_clk), .pins(pins));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    logic ok;
    @(posedge sys_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h00_0000, d};
    // Settled value is what the next rising edge samples
    do begin
      @(negedge sys_clk);
      ok = (waitreq === 1'b0);
      q = rdata;
      @(posedge sys_clk);
    end while (!ok);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(n, {24'h00_0000, e}, q);
  endtask : rc
  task automatic t_regs;
    rc("status", pwu_pkg::OFS_STATUS_CTRL, 8'h00);
    rc("enable", pwu_pkg::OFS_PIN_ENABLE, pwu_pkg::RST_PIN_ENABLE);
    bus(1'b1, pwu_pkg::OFS_STATUS_CTRL, 8'hFF, junk);
    rc("status", pwu_pkg::OFS_STATUS_CTRL, 8'h03);
    be <= 4'h0;
    bus(1'b1, pwu_pkg::OFS_PIN_ENABLE, 8'h33, junk);
    be <= 4'hF;
    rc("enable", pwu_pkg::OFS_PIN_ENABLE, 8'h00);
    bus(1'b1, pwu_pkg::OFS_POLARITY, 8'h5A, junk);
    rc("polarity", pwu_pkg::OFS_POLARITY, 8'h5A);
    rc("unmapped", 4'h2, pwu_pkg::UNMAPPED_READ[7:0]);
    bus(1'b1, pwu_pkg::OFS_PIN_ENABLE, 8'hFF, junk);
    chk("pullup", 32'h0000_00A5, 32'(pu));
    chk("pulldown", 32'h0000_005A, 32'(pd));
    pull_en <= 8'h0F;
    repeat (2) @(posedge sys_clk);
    chk("pullup", 32'h0000_0005, 32'(pu));
    chk("pulldown", 32'h0000_000A, 32'(pd));
    pull_en <= 8'hFF;
  endtask : t_regs
  task automatic t_edge;
    bus(1'b1, pwu_pkg::OFS_POLARITY, 8'h00, junk);
    bus(1'b1, pwu_pkg::OFS_PIN_ENABLE, 8'h01, junk);
    bus(1'b1, pwu_pkg::OFS_STATUS_CTRL, 8'h06, junk);
    u_pins.set(8'hFD);
    repeat (8) @(posedge sys_clk);
    rc("status", pwu_pkg::OFS_STATUS_CTRL, 8'h02);
    u_pins.set(8'hFC);
    repeat (8) @(posedge sys_clk);
    chk("irq", 32'h0000_0001, 32'(irq));
    bus(1'b1, pwu_pkg::OFS_STATUS_CTRL, 8'h00, junk);
    repeat (3) @(posedge sys_clk);
    chk("irq", 32'h0000_0000, 32'(irq));
    rc("status", pwu_pkg::OFS_STATUS_CTRL, 8'h08);
    bus(1'b1, pwu_pkg::OFS_STATUS_CTRL, 8'h06, junk);
    rc("status", pwu_pkg::OFS_STATUS_CTRL, 8'h02);
  endtask : t_edge
  task automatic t_level;
    @(posedge sys_clk);
    halt <= 1'b1;
    u_pins.set(8'hFB);
    bus(1'b1, pwu_pkg::OFS_POLARITY, 8'h04, junk);
    bus(1'b1, pwu_pkg::OFS_PIN_ENABLE, 8'h04, junk);
    bus(1'b1, pwu_pkg::OFS_STATUS_CTRL, 8'h07, junk);
    bus(1'b1, pwu_pkg::OFS_POWER_MODE, 8'h01, junk);
    rc("status", pwu_pkg::OFS_STATUS_CTRL, 8'h03);
    u_pins.set(8'hFF);
    repeat (8) @(posedge sys_clk);
    chk("wake", 32'h0000_0001, 32'(wake));
    bus(1'b1, pwu_pkg::OFS_STATUS_CTRL, 8'h07, junk);
    rc("status", pwu_pkg::OFS_STATUS_CTRL, 8'h0B);
    u_pins.set(8'hFB);
    repeat (5) @(posedge sys_clk);
    bus(1'b1, pwu_pkg::OFS_STATUS_CTRL, 8'h07, junk);
    rc("status", pwu_pkg::OFS_STATUS_CTRL, 8'h03);
  endtask : t_level
  task automatic t_stop;
    bus(1'b1, pwu_pkg::OFS_POWER_MODE, 8'h02, junk);
    u_pins.set(8'hFF);
    repeat (8) @(posedge sys_clk);
    chk("wake", 32'h0000_0001, 32'(wake));
    bus(1'b1, pwu_pkg::OFS_POWER_MODE, 8'h04, junk);
    bus(1'b1, pwu_pkg::OFS_POWER_MODE, 8'h00, junk);
    rc("enable", pwu_pkg::OFS_PIN_ENABLE, 8'h00);
    rc("status", pwu_pkg::OFS_STATUS_CTRL, 8'h00);
    rc("power", pwu_pkg::OFS_POWER_MODE, 8'h00);
  endtask : t_stop
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_edge();
    t_level();
    t_stop();
    print_verdict();
  end
endmodule : tb
